/* design/apd_pkg.sv */
// Constants, register layout and state types of the automatic power-down unit
package apd_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_APD_CTRL = 4'h0;
  localparam logic [3:0] OFS_POWER_MGMT_MODE_REGS_FIRST = 4'h1;
  localparam logic [3:0] OFS_POWER_MGMT_MODE_REGS_SECOND = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_PORT_DIR = 4'h4;
  localparam logic [3:0] OFS_PORT_OE = 4'h5;

  // Power-down control register fields
  localparam int APD_EN_BIT = 0;
  localparam int STROBE_POL_BIT = 1;
  localparam int PD_MODE_BIT = 2;

  // First power-management mode register fields
  localparam int FAST_OFF_BIT = 3;
  localparam int AUX_ARRAY_BLK_BIT = 4;
  localparam int AUX_MCELL_BLK_BIT = 5;

  // Second power-management mode register fields (signal blocking)
  localparam int ADDR_BLK_BIT = 0;
  localparam int CNTL0_BLK_BIT = 2;
  localparam int CNTL1_BLK_BIT = 3;
  localparam int CNTL2_BLK_BIT = 4;
  localparam int STROBE_BLK_BIT = 5;
  localparam int HW_BLK_BIT = 6;

  // Status register fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PD_BIT = 4;

  // Values after reset
  localparam logic [7:0] APD_CTRL_RST = 8'h04;
  localparam logic [7:0] POWER_MGMT_MODE_REGS_FIRST_RST = 8'h00;
  localparam logic [7:0] POWER_MGMT_MODE_REGS_SECOND_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;

  // Idle periods of the auxiliary clock before power-down
  localparam logic [3:0] IDLE_LIMIT = 4'hf;

  // Layout of the synchronised pin vector
  localparam int SYNC_W = 24;
  localparam int SY_AD_LSB = 0;
  localparam int SY_STROBE = 16;
  localparam int SY_AUX = 17;
  localparam int SY_SEL = 18;
  localparam int SY_RST = 19;
  localparam int SY_CNTL_LSB = 20;
  localparam int SY_HW = 23;

  typedef enum {st_run, st_counting, st_power_down} apd_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } sync_state_t;

  typedef struct packed {
    apd_state_t fsm;
    logic [3:0] idle_cnt;
    logic strobe_prev;
    logic aux_prev;
    logic [7:0] apd_ctrl;
    logic [7:0] power_mgmt_mode_regs_first;
    logic [7:0] power_mgmt_mode_regs_second;
    logic [7:0] port_dir;
    logic [7:0] port_oe;
    logic [7:0] rdata;
    logic [15:0] mem_ad;
    logic [7:0] pld_addr;
    logic [2:0] pld_cntl;
    logic pld_strobe;
    logic pld_hw;
    logic pld_aux_array;
    logic pld_aux_mcell;
    logic [3:0] mem_sel;
    logic data_oe;
    logic periph_oe;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    fsm: st_run,
    apd_ctrl: APD_CTRL_RST,
    power_mgmt_mode_regs_first: POWER_MGMT_MODE_REGS_FIRST_RST,
    power_mgmt_mode_regs_second: POWER_MGMT_MODE_REGS_SECOND_RST,
    port_dir: PORT_DIR_RST,
    default: '0
  };

endpackage

/* design/apd_pin_sync.sv */
// Two-stage synchroniser for every pin input of the power-down unit
`timescale 1ns/1ps
`default_nettype none
module apd_pin_sync (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [apd_pkg::SYNC_W-1:0] pins_in,
  output logic [apd_pkg::SYNC_W-1:0] stable_out
);

  apd_pkg::sync_state_t s_r;
  apd_pkg::sync_state_t s_nxt;

  // The first stage feeds only the second; nothing else looks at it
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pins_in;
    s_nxt.stable = s_r.meta;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign stable_out = s_r.stable;

endmodule
`default_nettype wire

/* design/auto_power_down_unit.sv */
// Automatic power-down unit: idle counter, power-down gating and mode registers
//
// Summary of operation
// - Output-enable status bit reads 1 when driving
// - Idle counter starts when strobe activity stops
// - Fifteen idle aux periods raise power-down flag
// - Strobe pulsing again ends power-down
// - Select low or reset high also wakes
// - Power-down blocks MCU bus from memories, PLDs
// - Power-down deselects all internal memories
// - Aux clock blocking never stops idle counter
// - PLDs and MCU I/O ports keep running in power-down
// - Data and peripheral pins tri-state in power-down
// - Select high disables flash, SRAM, I/O decode
// - Select never blocks signals or PLDs
// - Mode register writes apply at once
// - Blocking bits keep signals from the PLDs
// - Fast mode on by default; bit set disables
// - Enabling the unit enables power-down by default
// - Aux clock feeds macrocells and idle counter
// - Count only when enabled and strobe static
// - Fast-mode control is bit 3, first register
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module auto_power_down_unit (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Device pins, asynchronous to the system clock
  input wire logic [15:0] mcu_ad_in,
  input wire logic address_strobe_in,
  input wire logic aux_clock_in,
  input wire logic select_pin_in,
  input wire logic dev_reset_in,
  input wire logic [2:0] mcu_cntl_in,
  input wire logic high_write_pin_in,
  // Requests from neighbouring logic on the same clock
  input wire logic [3:0] mem_sel_req_in,
  input wire logic data_port_oe_req_in,
  input wire logic periph_oe_req_in,
  input wire logic [7:0] port_oe_term_in,
  // Gated outputs towards memories, PLDs and ports
  output logic power_down_flag_out,
  output logic [15:0] mem_ad_out,
  output logic [3:0] mem_sel_out,
  output logic [7:0] pld_addr_out,
  output logic [2:0] pld_cntl_out,
  output logic pld_strobe_out,
  output logic pld_high_write_out,
  output logic pld_aux_array_out,
  output logic pld_aux_mcell_out,
  output logic pld_fast_mode_out,
  output logic [15:0] addr_out_pins_out,
  output logic data_port_oe_out,
  output logic periph_oe_out,
  output logic [7:0] port_dir_out
);

  apd_pkg::core_state_t s_r;
  apd_pkg::core_state_t s_nxt;
  logic [apd_pkg::SYNC_W-1:0] pins_sync;

  // Signals that a blocking bit or power-down freezes hold their last value,
  // so the PLD sees static inputs and can settle into standby
  function automatic logic [15:0] pass_or_hold(input logic blocked,
                                               input logic [15:0] held,
                                               input logic [15:0] live);
    pass_or_hold = blocked ? held : live;
  endfunction

  // Status byte: idle count in the low nibble, power-down flag above it
  function automatic logic [7:0] status_byte(input logic [3:0] cnt,
                                             input logic pd);
    status_byte = 8'h00;
    status_byte[apd_pkg::STAT_CNT_LSB +: 4] = cnt;
    status_byte[apd_pkg::STAT_PD_BIT] = pd;
  endfunction

  // Every pin input goes through two flip-flops first
  apd_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .pins_in({high_write_pin_in, mcu_cntl_in, dev_reset_in, select_pin_in,
              aux_clock_in, address_strobe_in, mcu_ad_in}),
    .stable_out(pins_sync)
  );

  // Synchronised pin levels
  logic [15:0] ad_s;
  logic strobe_s;
  logic aux_s;
  logic sel_s;
  logic rst_s;
  logic [2:0] cntl_s;
  logic hw_s;

  assign ad_s = pins_sync[apd_pkg::SY_AD_LSB +: 16];
  assign strobe_s = pins_sync[apd_pkg::SY_STROBE];
  assign aux_s = pins_sync[apd_pkg::SY_AUX];
  assign sel_s = pins_sync[apd_pkg::SY_SEL];
  assign rst_s = pins_sync[apd_pkg::SY_RST];
  assign cntl_s = pins_sync[apd_pkg::SY_CNTL_LSB +: 3];
  assign hw_s = pins_sync[apd_pkg::SY_HW];

  // Decoded control bits and activity detection
  logic apd_en;
  logic strobe_pol;
  logic pd_mode_en;
  logic strobe_edge;
  logic aux_rise;
  logic strobe_static;
  logic wake_strobe;
  logic wake_select;
  logic wake_reset;
  logic wake;
  logic pd_now;
  logic mem_enable;

  assign apd_en = s_r.apd_ctrl[apd_pkg::APD_EN_BIT];
  assign strobe_pol = s_r.apd_ctrl[apd_pkg::STROBE_POL_BIT];
  assign pd_mode_en = s_r.apd_ctrl[apd_pkg::PD_MODE_BIT];
  assign strobe_edge = strobe_s ^ s_r.strobe_prev;
  // Aux edges reach the counter with no blocking bit in the path
  assign aux_rise = aux_s & ~s_r.aux_prev;
  assign strobe_static = ~strobe_edge & (strobe_s == strobe_pol);

  // Wake causes kept apart so each can be traced on its own
  assign wake_strobe = strobe_edge;
  assign wake_select = ~sel_s;
  assign wake_reset = rst_s;
  assign wake = wake_strobe | wake_select | wake_reset;
  assign pd_now = (s_r.fsm == apd_pkg::st_power_down);
  // Select high and power-down both drop the memory selects
  assign mem_enable = ~pd_now & ~sel_s;

  // Blocking bits, one per PLD input group. The select pin never enters
  // here, so deselecting the memories leaves every PLD input live.
  logic blk_addr;
  logic blk_cntl0;
  logic blk_cntl1;
  logic blk_cntl2;
  logic blk_strobe;
  logic blk_hw;
  logic blk_aux_array;
  logic blk_aux_mcell;

  assign blk_addr = s_r.power_mgmt_mode_regs_second[apd_pkg::ADDR_BLK_BIT];
  assign blk_cntl0 = s_r.power_mgmt_mode_regs_second[apd_pkg::CNTL0_BLK_BIT];
  assign blk_cntl1 = s_r.power_mgmt_mode_regs_second[apd_pkg::CNTL1_BLK_BIT];
  assign blk_cntl2 = s_r.power_mgmt_mode_regs_second[apd_pkg::CNTL2_BLK_BIT];
  assign blk_strobe = s_r.power_mgmt_mode_regs_second[apd_pkg::STROBE_BLK_BIT];
  assign blk_hw = s_r.power_mgmt_mode_regs_second[apd_pkg::HW_BLK_BIT];
  assign blk_aux_array = s_r.power_mgmt_mode_regs_first[apd_pkg::AUX_ARRAY_BLK_BIT];
  assign blk_aux_mcell = s_r.power_mgmt_mode_regs_first[apd_pkg::AUX_MCELL_BLK_BIT];

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe_prev = strobe_s;
    s_nxt.aux_prev = aux_s;
    s_nxt.rdata = 8'h00;

    // Idle counter and power-down sequencing
    case (s_r.fsm)
      apd_pkg::st_run: begin
        s_nxt.idle_cnt = 4'h0;
        if (apd_en && strobe_static) begin
          s_nxt.fsm = apd_pkg::st_counting;
        end
      end
      apd_pkg::st_counting: begin
        if (!apd_en || strobe_edge) begin
          s_nxt.fsm = apd_pkg::st_run;
          s_nxt.idle_cnt = 4'h0;
        end else if (s_r.idle_cnt == apd_pkg::IDLE_LIMIT) begin
          // A saturated count enters power-down once the mode bit is set,
          // so a late write to the mode bit still takes effect at once
          if (pd_mode_en && strobe_static) begin
            s_nxt.fsm = apd_pkg::st_power_down;
          end
        end else if (aux_rise && strobe_static) begin
          if (s_r.idle_cnt == apd_pkg::IDLE_LIMIT - 4'h1) begin
            s_nxt.idle_cnt = apd_pkg::IDLE_LIMIT;
            if (pd_mode_en) begin
              s_nxt.fsm = apd_pkg::st_power_down;
            end
          end else begin
            s_nxt.idle_cnt = s_r.idle_cnt + 4'h1;
          end
        end
      end
      apd_pkg::st_power_down: begin
        if (!apd_en || wake) begin
          s_nxt.fsm = apd_pkg::st_run;
          s_nxt.idle_cnt = 4'h0;
        end
      end
      default: begin
        s_nxt.fsm = apd_pkg::st_run;
        s_nxt.idle_cnt = 4'h0;
      end
    endcase

    // MCU bus to the memories is frozen during power-down
    s_nxt.mem_ad = pass_or_hold(pd_now, s_r.mem_ad, ad_s);
    s_nxt.mem_sel = mem_sel_req_in & {4{mem_enable}};

    // PLD address: held in power-down or when its blocking bit is set
    s_nxt.pld_addr = 8'(pass_or_hold(pd_now | blk_addr, {8'h00, s_r.pld_addr},
                                     {8'h00, ad_s[7:0]}));
    // Control pins, strobe and high-byte write, each with its own bit
    if (blk_cntl0) begin
      s_nxt.pld_cntl[0] = s_r.pld_cntl[0];
    end else begin
      s_nxt.pld_cntl[0] = cntl_s[0];
    end
    if (blk_cntl1) begin
      s_nxt.pld_cntl[1] = s_r.pld_cntl[1];
    end else begin
      s_nxt.pld_cntl[1] = cntl_s[1];
    end
    if (blk_cntl2) begin
      s_nxt.pld_cntl[2] = s_r.pld_cntl[2];
    end else begin
      s_nxt.pld_cntl[2] = cntl_s[2];
    end
    if (blk_strobe) begin
      s_nxt.pld_strobe = s_r.pld_strobe;
    end else begin
      s_nxt.pld_strobe = strobe_s;
    end
    if (blk_hw) begin
      s_nxt.pld_hw = s_r.pld_hw;
    end else begin
      s_nxt.pld_hw = hw_s;
    end
    // Aux clock to the array and macrocells; the counter path above is separate
    if (blk_aux_array) begin
      s_nxt.pld_aux_array = 1'b0;
    end else begin
      s_nxt.pld_aux_array = aux_s;
    end
    if (blk_aux_mcell) begin
      s_nxt.pld_aux_mcell = 1'b0;
    end else begin
      s_nxt.pld_aux_mcell = aux_s;
    end

    // Pin drivers: data and peripheral ports float in power-down,
    // MCU I/O and PLD outputs keep running untouched
    if (pd_now) begin
      s_nxt.data_oe = 1'b0;
      s_nxt.periph_oe = 1'b0;
    end else begin
      s_nxt.data_oe = data_port_oe_req_in;
      s_nxt.periph_oe = periph_oe_req_in;
    end
    s_nxt.port_oe = s_r.port_dir | port_oe_term_in;

    // Register writes take effect on the next edge
    if (reg_wr_in) begin
      case (reg_addr_in)
        apd_pkg::OFS_APD_CTRL: begin
          s_nxt.apd_ctrl = reg_wdata_in;
        end
        apd_pkg::OFS_POWER_MGMT_MODE_REGS_FIRST: begin
          s_nxt.power_mgmt_mode_regs_first = reg_wdata_in;
        end
        apd_pkg::OFS_POWER_MGMT_MODE_REGS_SECOND: begin
          s_nxt.power_mgmt_mode_regs_second = reg_wdata_in;
        end
        apd_pkg::OFS_PORT_DIR: begin
          s_nxt.port_dir = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped offsets read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        apd_pkg::OFS_APD_CTRL: begin
          s_nxt.rdata = s_r.apd_ctrl;
        end
        apd_pkg::OFS_POWER_MGMT_MODE_REGS_FIRST: begin
          s_nxt.rdata = s_r.power_mgmt_mode_regs_first;
        end
        apd_pkg::OFS_POWER_MGMT_MODE_REGS_SECOND: begin
          s_nxt.rdata = s_r.power_mgmt_mode_regs_second;
        end
        apd_pkg::OFS_STATUS: begin
          s_nxt.rdata = status_byte(s_r.idle_cnt, pd_now);
        end
        apd_pkg::OFS_PORT_DIR: begin
          s_nxt.rdata = s_r.port_dir;
        end
        apd_pkg::OFS_PORT_OE: begin
          s_nxt.rdata = s_r.port_oe;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // Single state register; the clock enable freezes everything
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= apd_pkg::CORE_RST;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out = s_r.rdata;
  assign power_down_flag_out = pd_now;
  assign mem_ad_out = s_r.mem_ad;
  assign mem_sel_out = s_r.mem_sel;
  assign pld_addr_out = s_r.pld_addr;
  assign pld_cntl_out = s_r.pld_cntl;
  assign pld_strobe_out = s_r.pld_strobe;
  assign pld_high_write_out = s_r.pld_hw;
  assign pld_aux_array_out = s_r.pld_aux_array;
  assign pld_aux_mcell_out = s_r.pld_aux_mcell;
  // Fast mode is on while the bit is clear; power-down does not touch it
  assign pld_fast_mode_out = ~s_r.power_mgmt_mode_regs_first[apd_pkg::FAST_OFF_BIT];
  // Address outputs are undefined in power-down; the frozen bus is shown
  assign addr_out_pins_out = s_r.mem_ad;
  assign data_port_oe_out = s_r.data_oe;
  assign periph_oe_out = s_r.periph_oe;
  assign port_dir_out = s_r.port_dir;

endmodule
`default_nettype wire

/* verif/apd_chk.sv */
// Port checker of the automatic power-down unit
`timescale 1ns/1ps
`default_nettype none
module apd_chk (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic address_strobe_in,
  input wire logic aux_clock_in,
  input wire logic select_pin_in,
  input wire logic dev_reset_in,
  input wire logic [3:0] mem_sel_req_in,
  input wire logic power_down_flag_out,
  input wire logic [15:0] mem_ad_out,
  input wire logic [3:0] mem_sel_out,
  input wire logic pld_fast_mode_out,
  input wire logic data_port_oe_out,
  input wire logic periph_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] aux_rises_r;
  logic aux_d_r;
  logic strobe_d_r;
  // Raw aux rises since the last strobe edge; raw pins lead the synchroniser, so a lower bound
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aux_rises_r <= 8'h00;
      aux_d_r <= 1'b0;
      strobe_d_r <= 1'b0;
    end else begin
      aux_d_r <= aux_clock_in;
      strobe_d_r <= address_strobe_in;
      if (address_strobe_in != strobe_d_r) aux_rises_r <= 8'h00;
      else if (aux_clock_in && !aux_d_r && aux_rises_r != 8'hff)
        aux_rises_r <= aux_rises_r + 8'h01;
    end
  end
  // Power-down is judged only once the flag has settled for a few cycles
  sequence s_pd_held; power_down_flag_out[*3]; endsequence
  sequence s_sel_low; !select_pin_in[*6]; endsequence
  property p_pd_desel; s_pd_held |-> mem_sel_out == 4'h0; endproperty
  a_pd_desel: assert property (p_pd_desel) else $error("memory selected in power-down");
  property p_pd_tri; s_pd_held |-> !data_port_oe_out && !periph_oe_out; endproperty
  a_pd_tri: assert property (p_pd_tri) else $error("port driven in power-down");
  property p_pd_frozen; s_pd_held |-> $stable(mem_ad_out); endproperty
  a_pd_frozen: assert property (p_pd_frozen) else $error("memory bus moved in power-down");
  property p_sel_wake; s_sel_low |-> !power_down_flag_out; endproperty
  a_sel_wake: assert property (p_sel_wake) else $error("select low did not wake");
  property p_rst_wake; dev_reset_in[*6] |-> !power_down_flag_out; endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset pin did not wake");
  property p_sel_off; select_pin_in[*6] |-> mem_sel_out == 4'h0; endproperty
  a_sel_off: assert property (p_sel_off) else $error("memory selected while deselected");
  property p_sel_on;
    s_sel_low ##0 (!power_down_flag_out && !$past(power_down_flag_out))
      |-> mem_sel_out == $past(mem_sel_req_in);
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("select low blocked a memory");
  property p_fast_rst; $rose(rst_b_in) |-> pld_fast_mode_out; endproperty
  a_fast_rst: assert property (p_fast_rst) else $error("fast mode off after reset");
  property p_idle15; $rose(power_down_flag_out) |-> aux_rises_r >= 8'h0e; endproperty
  a_idle15: assert property (p_idle15) else $error("power-down before idle count");
endmodule
bind auto_power_down_unit apd_chk u_apd_chk (.clk_sys_in, .rst_b_in, .address_strobe_in,
  .aux_clock_in, .select_pin_in, .dev_reset_in, .mem_sel_req_in, .power_down_flag_out,
  .mem_ad_out, .mem_sel_out, .pld_fast_mode_out, .data_port_oe_out, .periph_oe_out);
`default_nettype wire

/* verif/mcu_bus_model.sv */
// Behavioural MCU side: address strobe and free-running auxiliary clock
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_model (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic pulse_in,
  input wire logic level_in,
  output logic address_strobe_out,
  output logic aux_clock_out
);
  logic [2:0] div_r;
  // Aux clock at an eighth of the system rate, well inside the sampling limit
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign aux_clock_out = div_r[2];
  // Strobe toggles every other cycle while the bus is busy, else rests at the given level
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      address_strobe_out <= 1'b0;
    end else if (pulse_in) begin
      if (div_r[0]) address_strobe_out <= ~address_strobe_out;
    end else begin
      address_strobe_out <= level_in;
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench of the automatic power-down unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk_sys_in, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, pulse = 1'b0;
  logic select_pin_in = 1'b1, dev_reset_in = 1'b0, level = 1'b0, data_port_oe_req_in = 1'b1;
  logic address_strobe_in, aux_clock_in, power_down_flag_out, pld_fast_mode_out;
  logic pld_aux_array_out, pld_aux_mcell_out, data_port_oe_out, periph_oe_out;
  logic [7:0] port_dir_out;
  logic [3:0] reg_addr_in = 4'h0, mem_sel_req_in = 4'hf, mem_sel_out;
  logic [7:0] reg_wdata_in = 8'h00, port_oe_term_in = 8'h81, reg_rdata_out, pld_addr_out, rd_v;
  logic [15:0] mcu_ad_in = 16'h0000, mem_ad_out, snap;
  int num_errors = 0;
  int tests_run = 0;
  // Reset values, read-only and unmapped places, then read-back of written registers
  row_t rows [10] = '{'{4'h0, 1'b0, 8'h00, 8'h04}, '{4'h1, 1'b0, 8'h00, 8'h00},
    '{4'h2, 1'b0, 8'h00, 8'h00}, '{4'h4, 1'b0, 8'h00, 8'h00}, '{4'h5, 1'b0, 8'h00, 8'h81},
    '{4'h4, 1'b1, 8'h5a, 8'h5a}, '{4'h5, 1'b1, 8'hff, 8'hdb}, '{4'hf, 1'b1, 8'h33, 8'h00},
    '{4'h3, 1'b1, 8'hff, 8'h00}, '{4'h1, 1'b1, 8'h08, 8'h08}};

  mcu_bus_model u_mcu (.clk_sys_in, .rst_b_in, .pulse_in(pulse), .level_in(level),
    .address_strobe_out(address_strobe_in), .aux_clock_out(aux_clock_in));
  auto_power_down_unit DUT (.clk_sys_in, .rst_b_in, .ce_in(1'b1), .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mcu_ad_in, .address_strobe_in, .aux_clock_in,
    .select_pin_in, .dev_reset_in, .mcu_cntl_in(3'h0), .high_write_pin_in(1'b0),
    .mem_sel_req_in, .data_port_oe_req_in, .periph_oe_req_in(1'b1), .port_oe_term_in,
    .power_down_flag_out, .mem_ad_out, .mem_sel_out, .pld_addr_out, .pld_cntl_out(),
    .pld_strobe_out(), .pld_high_write_out(), .pld_aux_array_out, .pld_aux_mcell_out,
    .pld_fast_mode_out, .addr_out_pins_out(), .data_port_oe_out, .periph_oe_out,
    .port_dir_out);

  // Clock at 50 MHz
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Sampling at the falling edge keeps checks clear of the launch edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_sys_in);
    rd_v = reg_rdata_out;
  endtask
  // Bounded wait on the flag; running out counts as a failure
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 400 && power_down_flag_out !== v; i++) @(negedge clk_sys_in);
    if (power_down_flag_out !== v) begin
      num_errors++;
      conclude();
    end
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    wait_n(1);
    chk(16'(pld_fast_mode_out), 16'h0001);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(16'(rd_v), 16'(rows[i].e));
    end
    wait_n(2);
    chk(16'(pld_fast_mode_out), 16'h0000);
    chk(16'(port_dir_out), 16'h005a);
    wr(4'h1, 8'h00);
    @(posedge clk_sys_in);
    mcu_ad_in <= 16'h1234;
    wait_n(6);
    chk(16'(pld_addr_out), 16'h0034);
    chk(16'(mem_sel_out), 16'h0000);
    chk(16'(pld_fast_mode_out), 16'h0001);
    // Low address blocked from the PLDs while the memory bus still follows the pins
    wr(4'h2, 8'h01);
    mcu_ad_in <= 16'h5678;
    wait_n(6);
    chk(16'(pld_addr_out), 16'h0034);
    chk(mem_ad_out, 16'h5678);
    wr(4'h2, 8'h00);
    @(posedge clk_sys_in);
    select_pin_in <= 1'b0;
    mem_sel_req_in <= 4'h5;
    wait_n(6);
    chk(16'(mem_sel_out), 16'h0005);
    // Strobe static at the wrong level, then pulsing: no count either way
    @(posedge clk_sys_in);
    select_pin_in <= 1'b1;
    wr(4'h0, 8'h07);
    wait_n(300);
    chk(16'(power_down_flag_out), 16'h0000);
    pulse <= 1'b1;
    level <= 1'b1;
    wait_n(300);
    chk(16'(power_down_flag_out), 16'h0000);
    // Power-down mode off: the count saturates at fifteen and the flag stays low
    wr(4'h0, 8'h03);
    pulse <= 1'b0;
    wait_n(300);
    rd(4'h3);
    chk(16'(rd_v), 16'h000f);
    // Aux blocked from the PLDs, then each of the three wake causes
    wr(4'h1, 8'h30);
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, 8'h07);
      wait_flag(1'b1);
      rd(4'h3);
      chk(16'(rd_v), 16'h001f);
      chk(16'(pld_aux_array_out), 16'h0000);
      chk(16'(pld_aux_mcell_out), 16'h0000);
      snap = mem_ad_out;
      @(posedge clk_sys_in);
      mcu_ad_in <= ~mcu_ad_in;
      wait_n(5);
      chk(mem_ad_out, snap);
      chk(16'(mem_sel_out), 16'h0000);
      chk(16'({data_port_oe_out, periph_oe_out}), 16'h0000);
      @(posedge clk_sys_in);
      case (k)
        0: pulse <= 1'b1;
        1: select_pin_in <= 1'b0;
        default: dev_reset_in <= 1'b1;
      endcase
      wait_flag(1'b0);
      wait_n(2);
      chk(16'(data_port_oe_out), 16'h0001);
      @(posedge clk_sys_in);
      pulse <= 1'b0;
      select_pin_in <= 1'b1;
      dev_reset_in <= 1'b0;
    end
    // Reset in mid-run: control register and fast mode return to reset values
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    wait_n(1);
    chk(16'(pld_fast_mode_out), 16'h0001);
    chk(16'(power_down_flag_out), 16'h0000);
    rd(4'h0);
    chk(16'(rd_v), 16'h0004);
    conclude();
  end
endmodule
`default_nettype wire
